//--- common/ofdmsm_params.svh
// constants of the ofdm subcarrier mapper
`ifndef OFDMSM_PARAMS_SVH
`define OFDMSM_PARAMS_SVH

`define OFDMSM_IQ_W          12
`define OFDMSM_SET_HALF      7'h32
`define OFDMSM_SET_FULL      7'h64
`define OFDMSM_LAST_BIN      7'h7f
`define OFDMSM_NBIN          128
`define OFDMSM_POS_MAX       61
`define OFDMSM_NEG_FIRST     67
`define OFDMSM_GUARD_EDGE    57
`define OFDMSM_GUARD_OUTER   61
`define OFDMSM_GUARD_HALF    5
`define OFDMSM_UPPER_OFS     90
`define OFDMSM_PILOT_EDGE    55
`define OFDMSM_PILOT_STEP    10
`define OFDMSM_DATA_LOWER_OFS 56
`define OFDMSM_DATA_UPPER_OFS 49
`define OFDMSM_DATA_LAST     7'h63
`define OFDMSM_PRBS_LEN      7'h7f
`define OFDMSM_PRBS_MAX      7'h7e
`define OFDMSM_SPREAD_OFS    7'h06
// bit n set means p[n] = -1
`define OFDMSM_PRBS          127'h7f1d8a5f542de72b306d746440934f70
// pilot magnitude, 1/sqrt2 at a full scale of 1024
`define OFDMSM_PILOT_AMP     12'h2d4
// guard to data power ratio, right shift of guard values
`define OFDMSM_GUARD_SHIFT   0

`endif

//--- common/ofdmsm_pkg.sv
// types of the ofdm subcarrier mapper
`include "ofdmsm_params.svh"
package ofdmsm_pkg;

    typedef struct packed {
        logic signed [`OFDMSM_IQ_W-1:0] re;
        logic signed [`OFDMSM_IQ_W-1:0] im;
    } ofdmsm_cplx_t;

    typedef enum logic [1:0] {
        OFDMSM_HDR  = 2'b00,
        OFDMSM_LOW  = 2'b01,
        OFDMSM_MID  = 2'b10,
        OFDMSM_HIGH = 2'b11
    } ofdmsm_mode_t;

    typedef enum logic [1:0] {
        OFDMSM_IDLE = 2'b00,
        OFDMSM_FILL = 2'b01,
        OFDMSM_EMIT = 2'b10
    } ofdmsm_state_t;

    typedef enum logic [1:0] {
        OFDMSM_K_ZERO  = 2'b00,
        OFDMSM_K_DATA  = 2'b01,
        OFDMSM_K_PILOT = 2'b10
    } ofdmsm_kind_t;

    typedef struct packed {
        ofdmsm_kind_t kind;
        logic         guard;
        logic [6:0]   idx;
    } ofdmsm_cls_t;

    typedef struct packed {
        logic         v;
        logic         last;
        logic [6:0]   bin;
        ofdmsm_kind_t kind;
        logic         guard;
        logic         conj;
        logic         swap;
        logic         neg;
        ofdmsm_cplx_t pil;
    } ofdmsm_pipe_t;

    typedef struct packed {
        logic         v;
        logic         last;
        logic [6:0]   bin;
        ofdmsm_cplx_t d;
    } ofdmsm_out_t;

    typedef struct packed {
        ofdmsm_state_t st;
        ofdmsm_mode_t  mode;
        logic [6:0]    cnt;
        logic          par;
        logic [6:0]    pair;
        logic          rdy_low;
        logic          rdy_dc;
        ofdmsm_pipe_t  p1;
        ofdmsm_out_t   o;
    } ofdmsm_st_t;

endpackage

//--- core/ofdmsm_mem.sv
// set buffer: one write port, one read port with registered data
`timescale 1ns/1ps
module ofdmsm_mem (
    input  wire logic                  clk_i,
    input  wire logic                  ce_i,
    input  wire logic                  we_i,
    input  wire logic [6:0]            waddr_i,
    input  ofdmsm_pkg::ofdmsm_cplx_t   wdata_i,
    input  wire logic [6:0]            raddr_i,
    output ofdmsm_pkg::ofdmsm_cplx_t   rdata_o
);
    ofdmsm_pkg::ofdmsm_cplx_t mem_r [0:99];

    // no reset: contents are always written before they are read
    always_ff @(posedge clk_i) begin
        if (ce_i) begin
            if (we_i) begin
                mem_r[waddr_i] <= wdata_i;
            end
            rdata_o <= mem_r[raddr_i];
        end
    end
endmodule

//--- core/ofdmsm_mapper.sv
// ofdm subcarrier mapper: data, guard and pilot bins in ifft input order
//
// Operation
// - at the two lowest rates sets of 50 fill the lower half directly and the upper half conjugated and reversed.
// - at the two lowest rates the odd symbol repeats the even one times the spreading sign of the pair.
// - at the middle rates sets of 100 go in order on the even symbol and reversed, re/im swapped, signed on the odd.
// - at the highest rates each symbol carries the next 100 values in order with no spreading.
// - at the highest rates values come from the dual-carrier stream instead of the normal stream.
// - every produced symbol carries ten guard bins, five at each band edge.
// - guard bins sit at logical subcarriers -61..-57 and 57..61.
// - lower guards copy data indices 0..4 and upper guards copy data indices 95..99.
// - the guard to data power ratio is a fixed design constant, unchanged within a packet.
// - twelve pilots sit at logical subcarriers -55..55 in steps of ten.
// - header pilots are the prbs sign of the pair index times the pattern, odd symbols also times the spread sign.
// - header and lowest rates use the pattern 1-j, -1+j, 1+j, -1-j at the listed pilot positions.
// - middle rates use 1+j at pilots 0, 3, 8, 11 and -1-j elsewhere, same sign structure.
// - spreading and pilot signs come from a constant table of 127 signs.
// - subcarriers 1..61 go to bins 1..61, -61..-1 to bins 67..127, bins 0 and 62..66 are zero.
`timescale 1ns/1ps
`include "ofdmsm_params.svh"
module ofdmsm_mapper (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  ce_i,
    input  wire logic                  pkt_start_i,
    input  ofdmsm_pkg::ofdmsm_mode_t   mode_i,
    input  wire logic                  low_valid_i,
    input  ofdmsm_pkg::ofdmsm_cplx_t   low_data_i,
    output logic                       low_ready_o,
    input  wire logic                  dc_valid_i,
    input  ofdmsm_pkg::ofdmsm_cplx_t   dc_data_i,
    output logic                       dc_ready_o,
    output logic                       out_valid_o,
    output logic                       out_last_o,
    output logic [6:0]                 out_bin_o,
    output ofdmsm_pkg::ofdmsm_cplx_t   out_data_o
);
    ////////////////////////////////////////////////////////////////////////
    // bin classification
    function automatic ofdmsm_pkg::ofdmsm_cls_t classify(input logic [6:0] bin);
        ofdmsm_pkg::ofdmsm_cls_t c;
        int f;
        int l;
        c = '0;
        f = 0;
        l = 0;
        if (int'(bin) <= `OFDMSM_POS_MAX) begin
            f = int'(bin);
        end else if (int'(bin) >= `OFDMSM_NEG_FIRST) begin
            f = int'(bin) - `OFDMSM_NBIN;
        end
        if (f == 0) begin
            c.kind = ofdmsm_pkg::OFDMSM_K_ZERO;
        end else if (f <= -`OFDMSM_GUARD_EDGE) begin
            c.kind  = ofdmsm_pkg::OFDMSM_K_DATA;
            c.guard = 1'b1;
            c.idx   = 7'(f + `OFDMSM_GUARD_OUTER);
        end else if (f >= `OFDMSM_GUARD_EDGE) begin
            c.kind  = ofdmsm_pkg::OFDMSM_K_DATA;
            c.guard = 1'b1;
            c.idx   = 7'(f - `OFDMSM_GUARD_EDGE + `OFDMSM_GUARD_HALF + `OFDMSM_UPPER_OFS);
        end else if ((f + `OFDMSM_PILOT_EDGE) % `OFDMSM_PILOT_STEP == 0) begin
            c.kind = ofdmsm_pkg::OFDMSM_K_PILOT;
            c.idx  = 7'((f + `OFDMSM_PILOT_EDGE) / `OFDMSM_PILOT_STEP);
        end else begin
            if (f < 0) begin
                l = f + `OFDMSM_DATA_LOWER_OFS;
                if (f >= -`OFDMSM_PILOT_EDGE) begin
                    l = l - (f + `OFDMSM_PILOT_EDGE) / `OFDMSM_PILOT_STEP - 1;
                end
            end else begin
                l = `OFDMSM_DATA_UPPER_OFS + f
                    - (f + `OFDMSM_PILOT_STEP / 2) / `OFDMSM_PILOT_STEP;
            end
            c.kind = ofdmsm_pkg::OFDMSM_K_DATA;
            c.idx  = 7'(l);
        end
        return c;
    endfunction

    // pilot pattern signs {re_neg, im_neg}
    function automatic logic [1:0] pilot_sign(input ofdmsm_pkg::ofdmsm_mode_t m,
                                              input logic [6:0] p);
        logic [1:0] s;
        s = 2'b11;
        if (m == ofdmsm_pkg::OFDMSM_MID) begin
            if (p == 7'h0 || p == 7'h3 || p == 7'h8 || p == 7'hb) begin
                s = 2'b00;
            end
        end else begin
            case (p)
                7'h0, 7'h3:             s = 2'b01;
                7'h1, 7'h2, 7'h4, 7'h5: s = 2'b10;
                7'h8, 7'hb:             s = 2'b00;
                default:                s = 2'b11;
            endcase
        end
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state
    localparam logic [126:0] PRBS = `OFDMSM_PRBS;

    ofdmsm_pkg::ofdmsm_st_t   s_r;
    ofdmsm_pkg::ofdmsm_st_t   s_nxt;
    ofdmsm_pkg::ofdmsm_cplx_t rd_data;
    ofdmsm_pkg::ofdmsm_cplx_t wr_data;
    logic                     wr_en;
    logic [6:0]               rd_addr;

    ofdmsm_mem u_mem (
        .clk_i   (clk_i),
        .ce_i    (ce_i),
        .we_i    (wr_en),
        .waddr_i (s_r.cnt),
        .wdata_i (wr_data),
        .raddr_i (rd_addr),
        .rdata_o (rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        ofdmsm_pkg::ofdmsm_cls_t  c;
        ofdmsm_pkg::ofdmsm_cplx_t v;
        logic [6:0]               set_last;
        logic [6:0]               sp_idx;
        logic                     spread_neg;
        logic                     pil_neg;
        logic [1:0]               ps;
        logic                     take;
        c          = '0;
        v          = '0;
        s_nxt      = s_r;
        rd_addr    = 7'h0;
        wr_en      = 1'b0;
        set_last   = 7'h0;
        ps         = 2'b00;
        // spread sign index: pair offset by six, modulo 127
        sp_idx     = (s_r.pair >= `OFDMSM_PRBS_LEN - `OFDMSM_SPREAD_OFS)
                   ? s_r.pair - (`OFDMSM_PRBS_LEN - `OFDMSM_SPREAD_OFS)
                   : s_r.pair + `OFDMSM_SPREAD_OFS;
        spread_neg = s_r.par & PRBS[sp_idx];
        pil_neg    = PRBS[s_r.pair] ^ spread_neg;
        wr_data    = (s_r.mode == ofdmsm_pkg::OFDMSM_HIGH) ? dc_data_i : low_data_i;
        take       = (s_r.rdy_low & low_valid_i) | (s_r.rdy_dc & dc_valid_i);
        set_last   = (s_r.mode == ofdmsm_pkg::OFDMSM_HDR || s_r.mode == ofdmsm_pkg::OFDMSM_LOW)
                   ? `OFDMSM_SET_HALF - 7'h1 : `OFDMSM_SET_FULL - 7'h1;
        s_nxt.p1   = '0;

        // output stage: memory data lines up with stage one
        s_nxt.o.v    = s_r.p1.v;
        s_nxt.o.last = s_r.p1.last;
        s_nxt.o.bin  = s_r.p1.bin;
        v = rd_data;
        if (s_r.p1.conj) begin
            v.im = -rd_data.im;
        end
        if (s_r.p1.swap) begin
            v.re = rd_data.im;
            v.im = rd_data.re;
        end
        if (s_r.p1.neg) begin
            v.re = -v.re;
            v.im = -v.im;
        end
        if (s_r.p1.guard) begin
            v.re = v.re >>> `OFDMSM_GUARD_SHIFT;
            v.im = v.im >>> `OFDMSM_GUARD_SHIFT;
        end
        case (s_r.p1.kind)
            ofdmsm_pkg::OFDMSM_K_DATA:  s_nxt.o.d = v;
            ofdmsm_pkg::OFDMSM_K_PILOT: s_nxt.o.d = s_r.p1.pil;
            default:                    s_nxt.o.d = '0;
        endcase

        case (s_r.st)
            ofdmsm_pkg::OFDMSM_FILL: begin
                if (take) begin
                    wr_en     = 1'b1;
                    s_nxt.cnt = s_r.cnt + 7'h1;
                    if (s_r.cnt == set_last) begin
                        s_nxt.st      = ofdmsm_pkg::OFDMSM_EMIT;
                        s_nxt.cnt     = 7'h0;
                        s_nxt.par     = 1'b0;
                        s_nxt.rdy_low = 1'b0;
                        s_nxt.rdy_dc  = 1'b0;
                    end
                end
            end
            ofdmsm_pkg::OFDMSM_EMIT: begin
                c            = classify(s_r.cnt);
                s_nxt.p1.v    = 1'b1;
                s_nxt.p1.last = (s_r.cnt == `OFDMSM_LAST_BIN);
                s_nxt.p1.bin  = s_r.cnt;
                s_nxt.p1.kind = c.kind;
                s_nxt.p1.guard = c.guard;
                rd_addr      = c.idx;
                if (c.kind == ofdmsm_pkg::OFDMSM_K_DATA) begin
                    case (s_r.mode)
                        ofdmsm_pkg::OFDMSM_MID: begin
                            if (s_r.par) begin
                                rd_addr        = `OFDMSM_DATA_LAST - c.idx;
                                s_nxt.p1.swap = 1'b1;
                                s_nxt.p1.neg  = spread_neg;
                            end
                        end
                        ofdmsm_pkg::OFDMSM_HIGH: rd_addr = c.idx;
                        default: begin
                            if (c.idx >= `OFDMSM_SET_HALF) begin
                                rd_addr        = `OFDMSM_DATA_LAST - c.idx;
                                s_nxt.p1.conj = 1'b1;
                            end
                            s_nxt.p1.neg = spread_neg;
                        end
                    endcase
                end else if (c.kind == ofdmsm_pkg::OFDMSM_K_PILOT) begin
                    // top rate pilots are produced elsewhere: zero here
                    if (s_r.mode == ofdmsm_pkg::OFDMSM_HIGH) begin
                        s_nxt.p1.kind = ofdmsm_pkg::OFDMSM_K_ZERO;
                    end
                    ps = pilot_sign(s_r.mode, c.idx) ^ {pil_neg, pil_neg};
                    s_nxt.p1.pil.re = ps[1] ? -`OFDMSM_PILOT_AMP : `OFDMSM_PILOT_AMP;
                    s_nxt.p1.pil.im = ps[0] ? -`OFDMSM_PILOT_AMP : `OFDMSM_PILOT_AMP;
                end
                s_nxt.cnt = s_r.cnt + 7'h1;
                if (s_r.cnt == `OFDMSM_LAST_BIN) begin
                    s_nxt.cnt = 7'h0;
                    if (s_r.mode == ofdmsm_pkg::OFDMSM_HIGH || s_r.par) begin
                        s_nxt.st      = ofdmsm_pkg::OFDMSM_FILL;
                        s_nxt.mode    = mode_i;
                        s_nxt.rdy_low = (mode_i != ofdmsm_pkg::OFDMSM_HIGH);
                        s_nxt.rdy_dc  = (mode_i == ofdmsm_pkg::OFDMSM_HIGH);
                        if (s_r.par) begin
                            s_nxt.pair = (s_r.pair == `OFDMSM_PRBS_MAX) ? 7'h0 : s_r.pair + 7'h1;
                        end
                    end else begin
                        s_nxt.par = 1'b1;
                    end
                end
            end
            default: begin
            end
        endcase

        // packet start restarts the pair count and drops any partial set
        if (pkt_start_i) begin
            s_nxt.st      = ofdmsm_pkg::OFDMSM_FILL;
            s_nxt.mode    = mode_i;
            s_nxt.cnt     = 7'h0;
            s_nxt.par     = 1'b0;
            s_nxt.pair    = 7'h0;
            s_nxt.rdy_low = (mode_i != ofdmsm_pkg::OFDMSM_HIGH);
            s_nxt.rdy_dc  = (mode_i == ofdmsm_pkg::OFDMSM_HIGH);
            s_nxt.p1      = '0;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    assign low_ready_o = s_r.rdy_low;
    assign dc_ready_o  = s_r.rdy_dc;
    assign out_valid_o = s_r.o.v;
    assign out_last_o  = s_r.o.last;
    assign out_bin_o   = s_r.o.bin;
    assign out_data_o  = s_r.o.d;
endmodule

//--- bench/ofdmsm_src.sv
// upstream constellation source model for the mapper input streams
`timescale 1ns/1ps
module ofdmsm_src #(
    parameter int OFS = 0
) (
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                en_i,
    input  wire logic                slow_i,
    input  wire logic                ready_i,
    output logic                     valid_o,
    output ofdmsm_pkg::ofdmsm_cplx_t data_o
);
    int                       k;
    ofdmsm_pkg::ofdmsm_cplx_t last;
    wire                      take = valid_o && ready_i;
    // idle data is the inverse of the last word, so a stale sample shows up
    assign data_o = valid_o ? {12'(OFS + k), 12'(OFS - 3 * k - 1)} : ~last;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            k       <= 0;
            last    <= '0;
            valid_o <= 1'b0;
        end else begin
            if (take) begin
                k    <= k + 1;
                last <= data_o;
            end
            // an offered word stays until taken; slow mode idles after each take
            valid_o <= (valid_o && !take) || (en_i && !(take && slow_i));
        end
    end
endmodule

//--- bench/ofdmsm_mapper_sva.sv
// assertions on the mapper ports
`timescale 1ns/1ps
module ofdmsm_chk (
    input wire logic                clk_i,
    input wire logic                rst_i,
    input wire logic                pkt_start_i,
    input wire logic                low_ready_o,
    input wire logic                dc_ready_o,
    input wire logic                out_valid_o,
    input wire logic                out_last_o,
    input wire logic [6:0]          out_bin_o,
    input ofdmsm_pkg::ofdmsm_cplx_t out_data_o
);
    default clocking dcb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // an abort may leave a stray bin, so timing checks wait for a quiet spell
    logic [2:0] quiet_r;
    logic [8:0] run_r;
    wire        rdy  = low_ready_o | dc_ready_o;
    wire        calm = (quiet_r == 3'h7) && !pkt_start_i;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            quiet_r <= 3'h7;
            run_r   <= 9'h000;
        end else begin
            quiet_r <= pkt_start_i ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
            run_r   <= out_valid_o ? run_r + 9'h001 : 9'h000;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_set_done;
        $fell(rdy) && calm;
    endsequence
    sequence s_first_bin;
        out_valid_o && (out_bin_o == 7'h00);
    endsequence
    AST_FIRST_BIN: assert property (s_set_done |-> ##2 s_first_bin)
        else $error("first bin late after set complete");
    AST_LAST_BIN: assert property (out_last_o |-> out_valid_o && out_bin_o == 7'h7f)
        else $error("last flag off bin 127");
    AST_BIN_STEP: assert property (out_valid_o && !out_last_o && calm |=>
        out_valid_o && out_bin_o == $past(out_bin_o) + 7'h01)
        else $error("bins not consecutive");
    AST_ZERO_BIN: assert property (out_valid_o && (out_bin_o == 7'h00 ||
        out_bin_o inside {[7'h3e:7'h42]}) |-> out_data_o == '0)
        else $error("unused bin not zero");
    AST_GUARD_HI: assert property (out_valid_o && calm && out_bin_o inside {[7'h39:7'h3c]}
        |-> out_data_o == $past(out_data_o, 6))
        else $error("upper guard not a data copy");
    AST_GUARD_LO: assert property (out_valid_o && calm && out_bin_o == 7'h48
        |-> out_data_o == $past(out_data_o, 5))
        else $error("lower guard not a data copy");
    AST_READY_ONE: assert property (!(low_ready_o && dc_ready_o))
        else $error("both streams ready");
    AST_NO_TAKE: assert property (out_valid_o && calm && out_bin_o < 7'h7c |-> !rdy)
        else $error("input taken during emission");
    AST_RUN_LEN: assert property ($fell(out_valid_o) && calm |->
        run_r == 9'h080 || run_r == 9'h100)
        else $error("symbol run length wrong");
    AST_PILOT: assert property (out_valid_o && ((out_bin_o <= 7'h37 &&
        out_bin_o % 7'h0a == 7'h05) || (out_bin_o >= 7'h49 && out_bin_o % 7'h0a == 7'h03))
        |-> out_data_o == '0 || (out_data_o.re inside {12'h2d4, 12'hd2c} &&
        out_data_o.im inside {12'h2d4, 12'hd2c}))
        else $error("pilot amplitude wrong");
endmodule
bind ofdmsm_mapper ofdmsm_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .pkt_start_i(pkt_start_i),
    .low_ready_o(low_ready_o), .dc_ready_o(dc_ready_o), .out_valid_o(out_valid_o),
    .out_last_o(out_last_o), .out_bin_o(out_bin_o), .out_data_o(out_data_o));

//--- bench/test_ofdm_subcarrier_mapper.sv
// self-checking bench of the subcarrier mapper
`timescale 1ns/1ps
`include "ofdmsm_params.svh"
module test_ofdm_subcarrier_mapper;
    localparam logic [126:0] PRBS = `OFDMSM_PRBS;
    logic                     clk_i = 1'b0;
    logic                     rst_i = 1'b1;
    logic                     pkt_start_i = 1'b0;
    logic                     low_en = 1'b0;
    logic                     dc_en = 1'b0;
    logic                     slow = 1'b0;
    logic                     ce_i = 1'b1;
    ofdmsm_pkg::ofdmsm_mode_t mode_i = ofdmsm_pkg::OFDMSM_HDR;
    logic                     low_valid_i, low_ready_o, dc_valid_i, dc_ready_o;
    logic                     out_valid_o, out_last_o;
    logic [6:0]               out_bin_o;
    ofdmsm_pkg::ofdmsm_cplx_t low_data_i, dc_data_i, out_data_o;
    int                       fail_count = 0;
    int                       checked = 0;
    int                       knd[128], ix[128];
    always #2 clk_i = ~clk_i;
    // a frozen mapper takes no word, so the sources only see ready while enabled
    ofdmsm_mapper dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .pkt_start_i(pkt_start_i),
        .mode_i(mode_i), .low_valid_i(low_valid_i), .low_data_i(low_data_i),
        .low_ready_o(low_ready_o), .dc_valid_i(dc_valid_i), .dc_data_i(dc_data_i),
        .dc_ready_o(dc_ready_o), .out_valid_o(out_valid_o), .out_last_o(out_last_o),
        .out_bin_o(out_bin_o), .out_data_o(out_data_o));
    ofdmsm_src #(.OFS(0)) u_low (.clk_i(clk_i), .rst_i(rst_i), .en_i(low_en), .slow_i(slow),
        .ready_i(low_ready_o & ce_i), .valid_o(low_valid_i), .data_o(low_data_i));
    ofdmsm_src #(.OFS(1000)) u_dc (.clk_i(clk_i), .rst_i(rst_i), .en_i(dc_en), .slow_i(1'b0),
        .ready_i(dc_ready_o & ce_i), .valid_o(dc_valid_i), .data_o(dc_data_i));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp_bit(input logic got, input logic exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask
    task automatic cmp_val(input logic [23:0] got, input logic [23:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    function automatic int sg(int n);
        return PRBS[n % 127] ? -1 : 1;
    endfunction
    // expected bin value; stream word k is {ofs+k, ofs-3k-1}
    function automatic logic [23:0] expv(int m, int odd, int pr, int base, int ofs, int b);
        int l, k, re, im, t, s, rs;
        l = ix[b];
        s = odd ? sg(pr + 6) : 1;
        rs = (l == 0 || l == 3 || l == 8 || l == 11) ? 1 : -1;
        if (knd[b] == 0 || (knd[b] == 2 && m == 3))
            return 24'h000000;
        if (knd[b] == 2) begin
            re = 'h2d4 * rs * sg(pr) * s;
            im = (m != 2 && l < 6) ? -re : re;
        end else begin
            k = (m == 3 || (m < 2 && l < 50) || (m == 2 && odd == 0)) ? l : 99 - l;
            re = ofs + base + k;
            im = ofs - 3 * (base + k) - 1;
            if (m < 2 && l >= 50)
                im = -im;
            if (m == 2 && odd == 1) begin
                t = re;
                re = im;
                im = t;
            end
            re = re * s;
            im = im * s;
        end
        return {re[11:0], im[11:0]};
    endfunction
    task automatic wait_sig(bit sel, bit lvl);
        int n;
        n = 0;
        @(negedge clk_i);
        while ((sel ? out_valid_o : (low_ready_o | dc_ready_o)) !== lvl && n < 3000) begin
            @(negedge clk_i);
            n++;
        end
        if (n == 3000) begin
            fail_count++;
            $display("Error at %0t: wait ran out", $time);
        end
    endtask
    task automatic chk_pair(int m, int pr, int base, int ofs, int nsym,
                            ofdmsm_pkg::ofdmsm_mode_t nm, bit keep);
        logic [23:0] e;
        wait_sig(0, 1'b1);
        wait_sig(0, 1'b0);
        @(posedge clk_i);
        mode_i <= nm;
        if (m == 3)
            dc_en <= keep;
        else
            low_en <= keep;
        wait_sig(1, 1'b1);
        for (int n = 0; n < nsym; n++) begin
            for (int b = 0; b < 128; b++) begin
                e = expv(m, n, pr, base, ofs, b);
                cmp_bit(out_valid_o, 1'b1, "valid");
                cmp_val(24'(out_bin_o), 24'(b), "bin");
                cmp_bit(out_last_o, b == 127, "last");
                cmp_bit(m == 3 ? low_ready_o : dc_ready_o, 1'b0, "stream");
                cmp_val(out_data_o, e, "data");
                @(negedge clk_i);
            end
        end
    endtask
    task automatic start(ofdmsm_pkg::ofdmsm_mode_t m);
        @(posedge clk_i);
        pkt_start_i <= 1'b1;
        mode_i <= m;
        @(posedge clk_i);
        pkt_start_i <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic sc_hdr_low();
        start(ofdmsm_pkg::OFDMSM_HDR);
        low_en <= 1'b1;
        chk_pair(0, 0, 0, 0, 2, ofdmsm_pkg::OFDMSM_LOW, 1'b1);
        chk_pair(1, 1, 50, 0, 2, ofdmsm_pkg::OFDMSM_LOW, 1'b0);
    endtask
    // the word held at the low pair's end is taken then dropped by the restart
    task automatic sc_mid_slow();
        start(ofdmsm_pkg::OFDMSM_MID);
        low_en <= 1'b1;
        slow <= 1'b1;
        chk_pair(2, 0, 101, 0, 2, ofdmsm_pkg::OFDMSM_MID, 1'b0);
    endtask
    task automatic sc_high_dc();
        start(ofdmsm_pkg::OFDMSM_HIGH);
        dc_en <= 1'b1;
        // freeze in mid-set: a word written twice or lost shows up in the data checks
        repeat (20) @(posedge clk_i);
        ce_i <= 1'b0;
        repeat (8) @(negedge clk_i);
        cmp_bit(dc_ready_o, 1'b1, "ready while frozen");
        cmp_bit(out_valid_o, 1'b0, "valid while frozen");
        @(posedge clk_i);
        ce_i <= 1'b1;
        chk_pair(3, 0, 0, 1000, 1, ofdmsm_pkg::OFDMSM_HIGH, 1'b1);
        chk_pair(3, 0, 100, 1000, 1, ofdmsm_pkg::OFDMSM_HIGH, 1'b0);
    endtask
    task automatic end_sim();
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        int nd;
        nd = 0;
        for (int f = -61; f <= 61; f++) begin
            knd[(f + 128) % 128] = (f == 0) ? 0 : ((f + 55) % 10 == 0 && f > -56 && f < 56) ? 2 : 1;
            ix[(f + 128) % 128] = (f <= -57) ? f + 61 : (f >= 57) ? f + 38 : (f + 55) / 10;
            if (knd[(f + 128) % 128] == 1 && f > -57 && f < 57) begin
                ix[(f + 128) % 128] = nd;
                nd++;
            end
        end
        for (int b = 62; b < 67; b++)
            knd[b] = 0;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        sc_hdr_low();
        sc_mid_slow();
        sc_high_dc();
        end_sim();
    end
    initial begin
        #80000;
        fail_count++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim();
    end
endmodule
